// ### core/asr_pkg.sv
// Package for the asynchronous static RAM host controller.
package asr_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  // ****************************************************************
  // Timing in ns and derived cycle counts at 125 MHz
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_CYCLE_NS    = 70;  // Read and write cycle time, least.
  localparam int T_AS_NS       = 0;   // Address setup before strobe.
  localparam int T_WP_NS       = 50;  // Write pulse width, least.
  localparam int T_WR_NS       = 5;   // Write recovery, least.
  localparam int T_AA_NS       = 70;  // Address access, most.
  localparam int T_OHZ_NS      = 25;  // Gate to output released, most.
  localparam int T_DH_NS       = 0;   // Data hold after strobe end.

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int AS_CYC  = ns_to_cyc(T_AS_NS);
  localparam int WP_CYC  = ns_to_cyc(T_WP_NS);
  localparam int WR_CYC  = ns_to_cyc(T_WR_NS);
  localparam int AA_CYC  = ns_to_cyc(T_AA_NS);
  localparam int OHZ_CYC = ns_to_cyc(T_OHZ_NS);
  localparam int DH_CYC  = ns_to_cyc(T_DH_NS);
  localparam int CYC_CYC = ns_to_cyc(T_CYCLE_NS);
  localparam int CNT_W   = 8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_SETUP = 6'h02,
    ST_WSTRB = 6'h04,
    ST_WREC  = 6'h08,
    ST_READ  = 6'h10,
    ST_RREL  = 6'h20
  } asr_state_e;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asr_req_s;

  typedef struct packed {
    logic              sel_n;
    logic              sel;
    logic              we_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic              dout_en;
  } asr_pins_s;

  typedef struct packed {
    asr_state_e        st;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  cyc;
    logic              wr;
    asr_pins_s         pins;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic              wdone;
    logic [DATA_W-1:0] in1;
    logic [DATA_W-1:0] in2;
    logic [DATA_W-1:0] in3;
  } asr_state_s;

endpackage : asr_pkg

// ### core/asr_host.sv
// Host controller driving an asynchronous 128K x 8 static RAM through its pins.
`timescale 1ns/10ps
module asr_host #(
  parameter int ADDR_W = asr_pkg::ADDR_W,
  parameter int DATA_W = asr_pkg::DATA_W
) (
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_ce,
  input  wire logic              i_req_valid,
  input  wire asr_pkg::asr_req_s i_req,
  output logic                   o_req_ready,
  output logic [DATA_W-1:0]      o_rdata,
  output logic                   o_rvalid,
  output logic                   o_wdone,
  input  wire logic              i_retain,
  output logic                   o_select_low_active_n,
  output logic                   o_select_high_active,
  output logic                   o_we_n,
  output logic                   o_oe_n,
  output logic [ADDR_W-1:0]      o_word_select_lines,
  output logic [DATA_W-1:0]      o_byte_lines,
  output logic                   o_byte_lines_oe,
  input  wire logic [DATA_W-1:0] i_byte_lines
);

  // ****************************************************************
  // State
  // ****************************************************************
  asr_pkg::asr_state_s s_q;
  asr_pkg::asr_state_s s_d;

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam logic [7:0] WP_C  = 8'(asr_pkg::WP_CYC);
  localparam logic [7:0] WR_C  = 8'(asr_pkg::WR_CYC);
  localparam logic [7:0] AA_C  = 8'(asr_pkg::AA_CYC);
  localparam logic [7:0] OHZ_C = 8'(asr_pkg::OHZ_CYC);
  localparam logic [7:0] AS_C  = 8'(asr_pkg::AS_CYC);
  localparam logic [7:0] CYC_C = 8'(asr_pkg::CYC_CYC);
  // The byte lines pass three flops, which a read must wait out after the access time.
  localparam int         SYNC_N = 3;
  localparam logic [7:0] RD_C   = AA_C + 8'(SYNC_N);

  // A countdown has run out once it reaches one; zero counts as run out as well.
  function automatic logic cnt_last(input logic [7:0] c);
    return (c <= 8'h01);
  endfunction : cnt_last

  // ****************************************************************
  // Request side
  // ****************************************************************
  // Requests are only taken from idle and never while retention is asked.
  assign o_req_ready = (s_q.st == asr_pkg::ST_IDLE) && !i_retain;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;
    s_d.wdone  = 1'b0;
    // Byte lines pass three flops; a change counts once stages two and three agree.
    s_d.in1    = i_byte_lines;
    s_d.in2    = s_q.in1;
    s_d.in3    = s_q.in2;
    if (s_q.cnt != 8'h00)
    begin
      s_d.cnt = s_q.cnt - 8'h01;
    end
    if (s_q.cyc != 8'h00)
    begin
      s_d.cyc = s_q.cyc - 8'h01;
    end
    unique case (s_q.st)
      asr_pkg::ST_IDLE:
      begin
        s_d.pins.we_n    = 1'b1;
        s_d.pins.oe_n    = 1'b1;
        s_d.pins.dout_en = 1'b0;
        s_d.pins.sel_n   = 1'b1;
        // Retention: high-active select held low, a rail level; others free.
        s_d.pins.sel     = !i_retain;
        // Ready does not show the cycle-time count, so a requester holds valid until taken.
        if (i_req_valid && !i_retain && s_q.cyc == 8'h00)
        begin
          // Address moves only while deselected.
          s_d.pins.addr  = i_req.addr;
          s_d.pins.dout  = i_req.wdata;
          s_d.wr         = i_req.we;
          s_d.cnt        = AS_C;
          s_d.st         = asr_pkg::ST_SETUP;
        end
      end
      asr_pkg::ST_SETUP:
      begin
        // The cycle-time count starts with the select, so back-to-back cycles stay spaced.
        if (cnt_last(s_q.cnt))
        begin
          s_d.pins.sel_n = 1'b0;
          s_d.cyc        = CYC_C;
          if (s_q.wr)
          begin
            // Strobe and select fall together so the memory never drives.
            s_d.pins.we_n    = 1'b0;
            s_d.pins.dout_en = 1'b1;
            s_d.cnt          = WP_C;
            s_d.st           = asr_pkg::ST_WSTRB;
          end
          else
          begin
            s_d.pins.oe_n = 1'b0;
            // Access time plus the synchroniser's delay, so the captured byte has settled.
            s_d.cnt       = RD_C;
            s_d.st        = asr_pkg::ST_READ;
          end
        end
      end
      asr_pkg::ST_WSTRB:
      begin
        // The strobe count covers the least write pulse width.
        if (cnt_last(s_q.cnt))
        begin
          // End the write with the strobe; data holds one cycle beyond it.
          s_d.pins.we_n = 1'b1;
          s_d.cnt       = WR_C;
          s_d.st        = asr_pkg::ST_WREC;
        end
      end
      asr_pkg::ST_WREC:
      begin
        s_d.pins.sel_n = 1'b1;
        s_d.pins.dout_en = 1'b0;
        // The host lets go of the byte lines together with the select, after the strobe.
        if (cnt_last(s_q.cnt))
        begin
          s_d.wdone = 1'b1;
          s_d.st    = asr_pkg::ST_IDLE;
        end
      end
      asr_pkg::ST_READ:
      begin
        // Take the byte only once the last two synchroniser stages agree. A bus that
        // never settles stalls the read; a working memory settles after its access time.
        if (cnt_last(s_q.cnt) && (s_q.in2 == s_q.in3))
        begin
          s_d.rdata      = s_q.in3;
          s_d.pins.oe_n  = 1'b1;
          s_d.pins.sel_n = 1'b1;
          s_d.cnt        = OHZ_C;
          s_d.st         = asr_pkg::ST_RREL;
        end
      end
      asr_pkg::ST_RREL:
      begin
        // Wait for the memory to let go of the byte lines before anything else.
        if (cnt_last(s_q.cnt))
        begin
          s_d.rvalid = 1'b1;
          s_d.st     = asr_pkg::ST_IDLE;
        end
      end
      default:
      begin
        s_d.st = asr_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      // Strobes and low-active select start high and the rest low, so the memory sees no stray write.
      s_q              <= '0;
      s_q.st           <= asr_pkg::ST_IDLE;
      s_q.pins.sel_n   <= 1'b1;
      s_q.pins.we_n    <= 1'b1;
      s_q.pins.oe_n    <= 1'b1;
    end
    else if (i_ce)
    begin
      // A low clock enable freezes every count, so pin timing stretches, never shrinks.
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_select_low_active_n = s_q.pins.sel_n;
  assign o_select_high_active  = s_q.pins.sel;
  assign o_we_n                = s_q.pins.we_n;
  assign o_oe_n                = s_q.pins.oe_n;
  assign o_word_select_lines   = s_q.pins.addr;
  assign o_byte_lines          = s_q.pins.dout;
  assign o_byte_lines_oe       = s_q.pins.dout_en;
  assign o_rdata               = s_q.rdata;
  assign o_rvalid              = s_q.rvalid;
  assign o_wdone               = s_q.wdone;

endmodule : asr_host

// ### testbench/asr_host_properties.sv
// Pin protocol checks for the static RAM host controller.
`timescale 1ns/10ps
module asr_host_properties #(
  parameter int ADDR_W = 17
) (
  input wire logic              i_clk,
  input wire logic              i_sys_rst,
  input wire logic              i_retain,
  input wire logic              o_select_low_active_n,
  input wire logic              o_select_high_active,
  input wire logic              o_we_n,
  input wire logic              o_oe_n,
  input wire logic [ADDR_W-1:0] o_word_select_lines,
  input wire logic              o_byte_lines_oe,
  input wire logic              o_rvalid
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  gate_off_write_a: assert property (!o_we_n || o_byte_lines_oe |-> o_oe_n)
    else $error("output gate low during write");
  read_strobe_high_a: assert property ($fell(o_oe_n) |-> o_we_n [*8])
    else $error("write strobe low during read");
  addr_change_safe_a: assert property ($changed(o_word_select_lines)
    |-> o_select_low_active_n || !o_select_high_active || o_we_n) else $error("address moved");
  no_contention_a: assert property (o_byte_lines_oe |-> $past(o_oe_n) && o_oe_n)
    else $error("host drives while memory may drive");
  retain_enter_a: assert property ($rose(i_retain) |-> ##[1:20] !o_select_high_active)
    else $error("retention not entered");
  retain_quiet_a: assert property ($fell(o_select_high_active) |-> o_select_low_active_n)
    else $error("retention entered while selected");
  write_pulse_a: assert property ($fell(o_we_n) |-> $fell(o_select_low_active_n)
    ##1 !o_we_n [*6] ##1 o_we_n) else $error("write pulse shape wrong");
  read_answer_a: assert property ($fell(o_oe_n) |-> ##16 o_rvalid)
    else $error("read answer late or missing");
endmodule : asr_host_properties

bind asr_host asr_host_properties #(.ADDR_W(ADDR_W)) u_props (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_retain(i_retain),
  .o_select_low_active_n(o_select_low_active_n), .o_select_high_active(o_select_high_active),
  .o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_word_select_lines(o_word_select_lines),
  .o_byte_lines_oe(o_byte_lines_oe), .o_rvalid(o_rvalid));

// ### testbench/asr_mem_model.sv
// Behavioural model of the asynchronous 128K x 8 static RAM.
`timescale 1ns/10ps
module asr_mem_model #(
  parameter int ACC_NS = 60,
  parameter int OH_NS  = 10
) (
  input  wire logic        i_sel_n,
  input  wire logic        i_sel,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic [16:0] i_addr,
  input  wire logic [7:0]  i_host_d,
  input  wire logic        i_host_en,
  output logic      [7:0]  o_bus
);
  logic [7:0] mem [0:131071];
  logic [7:0] junk = 8'h00;
  logic       on;
  logic       drv;
  logic       late;
  logic [16:0] a_hold;
  // Old read data lingers briefly after the address moves.
  assign #(OH_NS) a_hold = i_addr;
  assign on = !i_sel_n && i_sel;
  assign drv = on && i_we_n && !i_oe_n;
  // Drive starts late but stops at once, so a slow part never overlaps the host.
  assign #(ACC_NS) late = drv;
  // A released bus shows a moving pattern, never the last value.
  always #4 junk = junk + 8'h3b;
  always @(posedge i_we_n) if (on) mem[i_addr] = i_host_en ? i_host_d : junk;
  assign o_bus = i_host_en ? i_host_d : (drv && late) ? mem[a_hold] : junk;
endmodule : asr_mem_model

// ### testbench/tb.sv
// Self-checking bench for the static RAM host controller.
`timescale 1ns/10ps
module tb;
  logic i_clk = 0, i_sys_rst = 1, i_ce = 1, i_req_valid = 0, i_retain = 0;
  asr_pkg::asr_req_s i_req = '0;
  logic o_req_ready, o_rvalid, o_wdone, sel_n, sel, we_n, oe_n, d_en;
  logic [7:0] o_rdata, dout, bus;
  logic [16:0] addr;
  int n_errors = 0, tests_run = 0;
  logic [33:0] rows [9] = '{{1'b1, 17'h00000, 8'ha5, 8'h00}, {1'b1, 17'h1ffff, 8'h5a, 8'h00},
    {1'b1, 17'h00123, 8'h3c, 8'h00}, {1'b0, 17'h00000, 8'h00, 8'ha5},
    {1'b0, 17'h1ffff, 8'h00, 8'h5a}, {1'b0, 17'h00123, 8'h00, 8'h3c},
    {1'b1, 17'h00123, 8'hc3, 8'h00}, {1'b0, 17'h00123, 8'h00, 8'hc3},
    {1'b0, 17'h00000, 8'h00, 8'ha5}};
  always #4 i_clk = ~i_clk;
  asr_host uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_wdone(o_wdone), .i_retain(i_retain), .o_select_low_active_n(sel_n),
    .o_select_high_active(sel), .o_we_n(we_n), .o_oe_n(oe_n), .o_word_select_lines(addr),
    .o_byte_lines(dout), .o_byte_lines_oe(d_en), .i_byte_lines(bus));
  asr_mem_model #(.ACC_NS(asr_pkg::T_AA_NS)) u_mem (.i_sel_n(sel_n), .i_sel(sel), .i_we_n(we_n),
    .i_oe_n(oe_n), .i_addr(addr), .i_host_d(dout), .i_host_en(d_en), .o_bus(bus));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [16:0] x, input logic [16:0] g);
    tests_run++;
    if (g !== x)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic op(input logic w, input logic [16:0] a, input logic [7:0] d, e);
    int k;
    i_req_valid = 1;
    i_req = '{w, a, d};
    for (k = 0; sel_n && k < 40; k++) @(negedge i_clk);
    i_req_valid = 0;
    chk("address", a, addr);
    for (k = 0; !(o_rvalid || o_wdone) && k < 40; k++) @(negedge i_clk);
    if (w) chk("wdone", 17'h1, {16'h0, o_wdone});
    else chk("rdata", {9'h0, e}, {9'h0, o_rdata});
  endtask : op
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    #20us;
    n_errors++;
    end_of_test();
  end
  initial
  begin
    @(negedge i_clk);
    chk("reset pins", 17'he, {13'h0, sel_n, we_n, oe_n, d_en});
    @(negedge i_clk);
    i_sys_rst = 0;
    foreach (rows[i]) op(rows[i][33], rows[i][32:16], rows[i][15:8], rows[i][7:0]);
    i_retain = 1;
    repeat (3) @(negedge i_clk);
    chk("retention", 17'h0, {15'h0, sel, o_req_ready});
    i_retain = 0;
    repeat (3) @(negedge i_clk);
    chk("awake", 17'h3, {15'h0, sel, o_req_ready});
    // Frozen clock enable must hold a waiting request back.
    i_ce = 0;
    i_req_valid = 1;
    i_req = '{1'b0, 17'h1ffff, 8'h00};
    repeat (5) @(negedge i_clk);
    chk("frozen", 17'h1, {16'h0, sel_n});
    i_ce = 1;
    op(1'b0, 17'h1ffff, 8'h00, 8'h5a);
    // A reset in mid-run raises the strobes and low-active select, lowers the high-active select, and leaves the stored bytes alone.
    i_sys_rst = 1;
    @(negedge i_clk);
    chk("mid reset", 17'h38, {10'h0, sel, sel_n, we_n, oe_n, d_en, o_rvalid, o_wdone});
    i_sys_rst = 0;
    op(1'b0, 17'h00000, 8'h00, 8'ha5);
    end_of_test();
  end
endmodule : tb
